// ===== rtl/vectored_irq_enable_arbiter.sv
// Vectored interrupt enable, priority and arbitration logic.
// Assumes peripheral flags arrive on core_clk; external lines are async pins.
// Functional notes
// R1: With the global enable set, a source requests only when its enable and pending flag are both 1.
// R2: With the global enable clear, no source requests whatever its own enable holds.
// R3: External line 0 vectors to 0x0003 at order 0 under enable bit 0, pending cleared on vectoring.
// R4: External line 1 vectors to 0x0013 at order 2 under enable bit 2, pending cleared on vectoring.
// R5: Timer 0 overflow vectors to 0x000B at order 1 under enable bit 1, flag cleared on vectoring.
// R6: Timer 1 overflow vectors to 0x001B at order 3 under enable bit 3, flag cleared on vectoring.
// R7: Timer 2 vectors to 0x002B at order 5 on either overflow flag under enable bit 5, no auto clear.
// R8: Serial receive and transmit flags share 0x0023 at order 4 under enable bit 4, software clears.
// R9: Serial peripheral 0 vectors to 0x0033 at order 6 under enable bit 6 from four shared flags.
// R10: Conversion done vectors to 0x0053 at order 10 under extended enable bit 3, no auto clear.
// R11: Supply warning at 0x007B has a read-only flag, so only its enable stops re-vectoring.
// R12: Clock alarm and oscillator-fail flags live in indirect space and are never auto cleared.
// R13: Other sources vector every eight bytes in increasing order from 0x003B to 0x0093.
// R14: Each pending flag sets on its condition regardless of any enable bit.
// R15: Among requests of equal level the lowest fixed order number is serviced first.
// R16: High priority preempts a low priority routine; a high priority routine is never preempted.
// R17: Requests are sampled and decoded every clock, allowing a seven cycle minimum response.
`timescale 1ns/1ps
module vectored_irq_enable_arbiter (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // External interrupt pins, active low
  input  wire logic        ext_line0_input,
  input  wire logic        ext_line1_input,
  // Software access to the external pending flags
  input  wire logic [1:0]  ext_pending_set,
  input  wire logic [1:0]  ext_pending_clear,
  output logic             ext_line0_pending,
  output logic             ext_line1_pending,
  // Peripheral pending flags
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        serial_receive_flag,
  input  wire logic        serial_transmit_flag,
  input  wire logic        timer2_high_overflow_flag,
  input  wire logic        timer2_low_overflow_flag,
  input  wire logic        transfer_done_flag,
  input  wire logic        write_collision_flag,
  input  wire logic        mode_fault_flag,
  input  wire logic        receive_overrun_flag,
  input  wire logic        bus_event_flag,
  input  wire logic        clock_alarm_flag,
  input  wire logic        window_match_flag,
  input  wire logic        conversion_done_flag,
  input  wire logic        counter_array_flag,
  input  wire logic        comparator0_flag,
  input  wire logic        comparator1_flag,
  input  wire logic        timer3_overflow_flag,
  input  wire logic        supply_good_flag,
  input  wire logic        port_match_flag,
  input  wire logic        clock_osc_fail_flag,
  input  wire logic        serial_periph1_flag,
  // Hardware clear strobes to the timer flags
  output logic             timer0_flag_clear,
  output logic             timer1_flag_clear,
  // CPU core
  input  wire logic        cpu_vector_taken,
  input  wire logic        cpu_reti,
  output logic             cpu_irq_req,
  output logic      [15:0] cpu_irq_vector,
  output logic             in_service_low,
  output logic             in_service_high
);

  localparam int N = irq_pkg::NUM_SRC;
  localparam int W = irq_pkg::IDX_W;

  // ==========================================================
  // Registers
  logic [7:0]   enable_mask_ff;
  logic [6:0]   priority_ff;
  logic [7:0]   ext_enable1_ff;
  logic [7:0]   ext_priority1_ff;
  logic [3:0]   ext_enable2_ff;
  logic [3:0]   ext_priority2_ff;
  logic [7:0]   rdata_ff;

  logic [1:0]   ext_pend_ff;
  logic [1:0]   ext_prev_ff;
  logic         req_ff;
  logic [15:0]  vector_ff;
  logic [W-1:0] src_ff;
  logic         act_low_ff;
  logic         act_high_ff;
  logic         t0_clr_ff;
  logic         t1_clr_ff;

  logic [1:0]   ext_lvl;
  logic [N-1:0] pending;
  logic [N-1:0] enables;
  logic [N-1:0] high_lvl;
  logic [N-1:0] armed;
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic         hi_found;
  logic         lo_found;
  logic [W-1:0] hi_idx;
  logic [W-1:0] lo_idx;
  logic         nxt_req;
  logic [W-1:0] nxt_src;
  logic         taken;
  logic [7:0]   nxt_rdata;

  // ==========================================================
  // External lines
  pin_sync #(
    .WIDTH        (2)
  ) u_pin_sync (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .pin_async    ({ext_line1_input, ext_line0_input}),
    .pin_sync_out (ext_lvl)
  );

  assign taken = cpu_vector_taken && req_ff;

  // A falling edge sets the flag even if the same cycle vectors or clears it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ext_prev_ff <= 2'h3;
      ext_pend_ff <= 2'h0;
    end
    else
    begin
      ext_prev_ff <= ext_lvl;
      for (int i = 0; i < 2; i++)
      begin
        if ((ext_prev_ff[i] && !ext_lvl[i]) || ext_pending_set[i])      // see R14
          ext_pend_ff[i] <= 1'b1;
        else if (ext_pending_clear[i])
          ext_pend_ff[i] <= 1'b0;
        else if (taken && src_ff == irq_pkg::SRC_EXT0 && i == 0)        // see R3
          ext_pend_ff[i] <= 1'b0;
        else if (taken && src_ff == irq_pkg::SRC_EXT1 && i == 1)        // see R4
          ext_pend_ff[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Source table in fixed order; bit index is order and vector slot
  always_comb
  begin
    pending[0]  = ext_pend_ff[0];                                       // see R3
    pending[1]  = timer0_overflow_flag;                                 // see R5
    pending[2]  = ext_pend_ff[1];                                       // see R4
    pending[3]  = timer1_overflow_flag;                                 // see R6
    pending[4]  = serial_receive_flag | serial_transmit_flag;           // see R8
    pending[5]  = timer2_high_overflow_flag | timer2_low_overflow_flag; // see R7
    pending[6]  = transfer_done_flag | write_collision_flag             // see R9
                | mode_fault_flag | receive_overrun_flag;
    pending[7]  = bus_event_flag;                                       // see R13
    pending[8]  = clock_alarm_flag;                                     // see R12
    pending[9]  = window_match_flag;
    pending[10] = conversion_done_flag;                                 // see R10
    pending[11] = counter_array_flag;
    pending[12] = comparator0_flag;
    pending[13] = comparator1_flag;
    pending[14] = timer3_overflow_flag;
    // Read-only flag: software masks the enable to stop repeats
    pending[15] = supply_good_flag;                                     // see R11
    pending[16] = port_match_flag;
    pending[17] = clock_osc_fail_flag;                                  // see R12
    pending[18] = serial_periph1_flag;
  end

  assign enables  = {ext_enable2_ff, ext_enable1_ff, enable_mask_ff[6:0]};
  assign high_lvl = {ext_priority2_ff, ext_priority1_ff, priority_ff};

  // Global enable gates every source
  assign armed = enable_mask_ff[irq_pkg::GLOBAL_EN_BIT]                 // see R1
               ? (pending & enables) : '0;                              // see R2

  // A running high routine blocks all; a running low routine blocks low only
  assign hi_req = act_high_ff ? '0 : (armed & high_lvl);                // see R16
  assign lo_req = (act_high_ff || act_low_ff) ? '0 : (armed & ~high_lvl);

  fixed_order_pick #(
    .N     (N),
    .IDX_W (W)
  ) u_pick_high (
    .req   (hi_req),
    .found (hi_found),
    .idx   (hi_idx)
  );

  fixed_order_pick #(
    .N     (N),
    .IDX_W (W)
  ) u_pick_low (
    .req   (lo_req),
    .found (lo_found),
    .idx   (lo_idx)
  );

  // Level first, then the lowest fixed order within a level
  assign nxt_src = hi_found ? hi_idx : lo_idx;                          // see R15
  // Drop the request for the cycle the CPU takes it, as nesting state moves then
  assign nxt_req = (hi_found || lo_found) && !taken;

  // ==========================================================
  // Request and vector, decoded every clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      req_ff    <= 1'b0;
      src_ff    <= '0;
      vector_ff <= irq_pkg::VEC_RESET;
    end
    else
    begin
      req_ff    <= nxt_req;                                             // see R17
      src_ff    <= nxt_src;
      vector_ff <= irq_pkg::VEC_BASE                                    // see R13
                 + (16'(nxt_src) << irq_pkg::VEC_SHIFT);
    end
  end

  // ==========================================================
  // Nesting state
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      act_low_ff  <= 1'b0;
      act_high_ff <= 1'b0;
    end
    else if (taken)
    begin
      if (high_lvl[src_ff])                                             // see R16
        act_high_ff <= 1'b1;
      else
        act_low_ff  <= 1'b1;
    end
    else if (cpu_reti)
    begin
      if (act_high_ff)
        act_high_ff <= 1'b0;
      else
        act_low_ff  <= 1'b0;
    end
  end

  // ==========================================================
  // Timer flag clear strobes; one cycle each
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      t0_clr_ff <= 1'b0;
      t1_clr_ff <= 1'b0;
    end
    else
    begin
      t0_clr_ff <= taken && src_ff == irq_pkg::SRC_TIMER0;              // see R5
      t1_clr_ff <= taken && src_ff == irq_pkg::SRC_TIMER1;              // see R6
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      enable_mask_ff   <= irq_pkg::RST_BYTE;
      priority_ff      <= irq_pkg::RST_BYTE[6:0];
      ext_enable1_ff   <= irq_pkg::RST_BYTE;
      ext_priority1_ff <= irq_pkg::RST_BYTE;
      ext_enable2_ff   <= irq_pkg::RST_NIBBLE;
      ext_priority2_ff <= irq_pkg::RST_NIBBLE;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        irq_pkg::ADDR_ENABLE_MASK:   enable_mask_ff   <= sfr_wdata;
        irq_pkg::ADDR_PRIORITY:      priority_ff      <= sfr_wdata[6:0];
        irq_pkg::ADDR_EXT_ENABLE1:   ext_enable1_ff   <= sfr_wdata;
        irq_pkg::ADDR_EXT_PRIORITY1: ext_priority1_ff <= sfr_wdata;
        irq_pkg::ADDR_EXT_ENABLE2:   ext_enable2_ff   <= sfr_wdata[3:0];
        irq_pkg::ADDR_EXT_PRIORITY2: ext_priority2_ff <= sfr_wdata[3:0];
        default:                     ;
      endcase
    end
  end

  // ==========================================================
  // Register reads, one cycle after the strobe
  always_comb
  begin
    case (sfr_addr)
      irq_pkg::ADDR_ENABLE_MASK:   nxt_rdata = enable_mask_ff;
      irq_pkg::ADDR_PRIORITY:      nxt_rdata = {irq_pkg::PRIO_TOP_READ, priority_ff};
      irq_pkg::ADDR_EXT_ENABLE1:   nxt_rdata = ext_enable1_ff;
      irq_pkg::ADDR_EXT_PRIORITY1: nxt_rdata = ext_priority1_ff;
      irq_pkg::ADDR_EXT_ENABLE2:   nxt_rdata = {4'h0, ext_enable2_ff};
      irq_pkg::ADDR_EXT_PRIORITY2: nxt_rdata = {4'h0, ext_priority2_ff};
      default:                     nxt_rdata = irq_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_ff <= irq_pkg::RST_BYTE;
    else if (sfr_rd)
      rdata_ff <= nxt_rdata;
  end

  // ==========================================================
  // Outputs
  assign sfr_rdata         = rdata_ff;
  assign ext_line0_pending = ext_pend_ff[0];
  assign ext_line1_pending = ext_pend_ff[1];
  assign timer0_flag_clear = t0_clr_ff;
  assign timer1_flag_clear = t1_clr_ff;
  assign cpu_irq_req       = req_ff;
  assign cpu_irq_vector    = vector_ff;
  assign in_service_low    = act_low_ff;
  assign in_service_high   = act_high_ff;

endmodule

// ===== rtl/irq_pkg.sv
// Constants shared by the vectored interrupt logic.
// Assumes an 8-bit special function register bus and 19 vectored sources.
package irq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_ENABLE_MASK  = 8'ha8;
  localparam logic [7:0] ADDR_PRIORITY     = 8'hb8;
  localparam logic [7:0] ADDR_EXT_ENABLE1  = 8'he6;
  localparam logic [7:0] ADDR_EXT_PRIORITY1 = 8'hf6;
  localparam logic [7:0] ADDR_EXT_ENABLE2  = 8'he7;
  localparam logic [7:0] ADDR_EXT_PRIORITY2 = 8'hf7;

  // ==========================================================
  // Reset values and fields
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [3:0] RST_NIBBLE        = 4'h0;
  localparam int         GLOBAL_EN_BIT     = 7;
  localparam logic       PRIO_TOP_READ     = 1'b1;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ==========================================================
  // Sources in fixed order; the index is the arbitration order
  localparam int         NUM_SRC           = 19;
  localparam int         IDX_W             = 5;
  localparam logic [4:0] SRC_EXT0          = 5'h00;
  localparam logic [4:0] SRC_TIMER0        = 5'h01;
  localparam logic [4:0] SRC_EXT1          = 5'h02;
  localparam logic [4:0] SRC_TIMER1        = 5'h03;

  // ==========================================================
  // Vectors: base plus eight bytes per fixed order step
  localparam logic [15:0] VEC_BASE         = 16'h0003;
  localparam int          VEC_SHIFT        = 3;
  localparam logic [15:0] VEC_RESET        = 16'h0000;

endpackage

// ===== rtl/pin_sync.sv
// Two-stage synchroniser bank for asynchronous pins.
// Assumes inputs may change at any time relative to core_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync_out
);

  // ==========================================================
  // Per-bit chain; idle level is high for active-low lines
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end
        else
        begin
          meta_ff <= pin_async[gi];
          sync_ff <= meta_ff;
        end
      end
      assign pin_sync_out[gi] = sync_ff;
    end
  endgenerate

endmodule

// ===== rtl/fixed_order_pick.sv
// Lowest-index-wins picker over a request vector.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module fixed_order_pick #(
  parameter int N     = 19,
  parameter int IDX_W = 5
) (
  // Requests
  input  wire logic [N-1:0]     req,
  // Result
  output logic                  found,
  output logic      [IDX_W-1:0] idx
);

  // ==========================================================
  // Scan from the top down so the lowest index lands last
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx   = IDX_W'(i);
      end
    end
  end

endmodule

// ===== sim/irq_arbiter_checker.sv
// Port-level assertions for the vectored interrupt arbiter.
// Assumes it is bound to the arbiter top; mirrors the enable mask from bus writes.
`timescale 1ns/1ps
module irq_arbiter_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Flags
  input wire logic        ext_line0_input,
  input wire logic [1:0]  ext_pending_set,
  input wire logic        ext_line0_pending,
  input wire logic        timer0_overflow_flag,
  input wire logic        timer0_flag_clear,
  // CPU side
  input wire logic        cpu_vector_taken,
  input wire logic        cpu_reti,
  input wire logic        cpu_irq_req,
  input wire logic [15:0] cpu_irq_vector,
  input wire logic        in_service_low,
  input wire logic        in_service_high
);
  // ==========================================================
  // Helper logic
  logic [7:0] mask_ff;
  wire        taken = cpu_vector_taken && cpu_irq_req;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mask_ff <= 8'h00;
    else if (sfr_wr && sfr_addr == irq_pkg::ADDR_ENABLE_MASK)
      mask_ff <= sfr_wdata;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Assertions
  global_off_quiet_a: assert property (!mask_ff[7] && !$past(mask_ff[7])
    |-> !cpu_irq_req) else $error("request raised with global enable clear");
  vector_grid_a: assert property (cpu_irq_req |-> cpu_irq_vector[2:0] == 3'h3 &&
    cpu_irq_vector <= 16'h0093) else $error("vector off the eight byte grid");
  t0_clear_cause_a: assert property (timer0_flag_clear |->
    $past(taken && cpu_irq_vector == 16'h000b)) else $error("stray timer0 clear");
  t0_clear_pulse_a: assert property (taken && cpu_irq_vector == 16'h000b |=>
    timer0_flag_clear ##1 !timer0_flag_clear) else $error("timer0 clear not one pulse");
  ext0_hw_clear_a: assert property ((ext_line0_input [*4]) ##0 (taken &&
    cpu_irq_vector == 16'h0003 && !ext_pending_set[0]) |=> !ext_line0_pending)
    else $error("line0 pending kept after vectoring");
  high_no_preempt_a: assert property (in_service_high && $past(in_service_high)
    |-> !cpu_irq_req) else $error("request during high routine");
  reti_pops_high_a: assert property (cpu_reti && in_service_high |=> !in_service_high)
    else $error("return left high level in service");
  timer0_latency_a: assert property (mask_ff == 8'h82 && $past(mask_ff) == 8'h82 &&
    timer0_overflow_flag && !in_service_low && !in_service_high && !taken |=>
    cpu_irq_req && cpu_irq_vector == 16'h000b) else $error("timer0 request late");
  mask_readback_a: assert property (sfr_rd && sfr_addr == 8'ha8 |=>
    sfr_rdata == $past(mask_ff)) else $error("enable mask read back wrong");

  cover property (taken && in_service_low);
  cover property (taken && cpu_irq_vector == 16'h0093);
  cover property (in_service_low && in_service_high);
endmodule

bind vectored_irq_enable_arbiter irq_arbiter_checker chk (.*);

// ===== sim/cpu_flag_model.sv
// CPU fetch stand-in that takes requests after a chosen delay, plus timer flag sources.
// Assumes the bench arms taking with take_en and drives controls after an edge.
`timescale 1ns/1ps
module cpu_flag_model (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Bench control
  input wire logic       take_en,
  input wire logic [2:0] take_delay,
  input wire logic       reti_cmd,
  input wire logic [1:0] tmr_set,
  // Arbiter side
  input wire logic       cpu_irq_req,
  input wire logic       timer0_flag_clear,
  input wire logic       timer1_flag_clear,
  output logic           cpu_vector_taken,
  output logic           cpu_reti,
  output logic           timer0_overflow_flag,
  output logic           timer1_overflow_flag
);
  // ==========================================================
  // Fetch side: a slow answer lets the request stand a few cycles
  logic [3:0] wait_ff;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wait_ff <= 4'h0;
      cpu_vector_taken <= 1'b0;
      cpu_reti <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end
    else
    begin
      wait_ff <= (take_en && cpu_irq_req && !cpu_vector_taken) ? wait_ff + 4'h1 : 4'h0;
      cpu_vector_taken <= take_en && cpu_irq_req && !cpu_vector_taken &&
                          wait_ff >= {1'b0, take_delay};
      cpu_reti <= reti_cmd;
      // Set wins over the clear strobe, as a timer would do it
      timer0_overflow_flag <= tmr_set[0] | (timer0_overflow_flag & ~timer0_flag_clear);
      timer1_overflow_flag <= tmr_set[1] | (timer1_overflow_flag & ~timer1_flag_clear);
    end
  end
endmodule

// ===== sim/test_vectored_irq_enable_arbiter.sv
// Self-checking bench for the vectored interrupt arbiter.
// Assumes the checker binds itself and cpu_flag_model stands in for the CPU.
`timescale 1ns/1ps
module test_vectored_irq_enable_arbiter;
  logic        core_clk, rst_n, sfr_wr, sfr_rd, take_en, reti_cmd;
  logic        ext_line0_input, ext_line1_input, ext_line0_pending, ext_line1_pending;
  logic        timer0_overflow_flag, timer1_overflow_flag, timer0_flag_clear;
  logic        timer1_flag_clear, cpu_vector_taken, cpu_reti, cpu_irq_req;
  logic        in_service_low, in_service_high;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, x;
  logic [1:0]  ext_pending_set, ext_pending_clear, tmr_set, sub;
  logic [2:0]  take_delay;
  logic [15:0] cpu_irq_vector;
  logic [18:0] fl;
  int          bad_count, n_compared, a, b;
  wire [2:0]   st = {in_service_high, in_service_low, cpu_irq_req};
  // ==========================================================
  // Flag fan-out; sub picks which of a shared group fires
  wire serial_receive_flag = fl[4] & ~sub[0], serial_transmit_flag = fl[4] & sub[0];
  wire timer2_high_overflow_flag = fl[5] & sub[0], timer2_low_overflow_flag = fl[5] & ~sub[0];
  wire transfer_done_flag = fl[6] & (sub == 2'h0), write_collision_flag = fl[6] & (sub == 2'h1);
  wire mode_fault_flag = fl[6] & (sub == 2'h2), receive_overrun_flag = fl[6] & (sub == 2'h3);
  wire bus_event_flag = fl[7], clock_alarm_flag = fl[8], window_match_flag = fl[9];
  wire conversion_done_flag = fl[10], counter_array_flag = fl[11], comparator0_flag = fl[12];
  wire comparator1_flag = fl[13], timer3_overflow_flag = fl[14], supply_good_flag = fl[15];
  wire port_match_flag = fl[16], clock_osc_fail_flag = fl[17], serial_periph1_flag = fl[18];

  vectored_irq_enable_arbiter DUT (.*);
  cpu_flag_model cpu (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] exp_vec(input int i);
    return 16'h0003 + 16'(i * 8);
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e, input string what);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e, what);
    cyc(1);
  endtask

  task automatic set_en(input logic [18:0] e, input logic g);
    wr(8'ha8, {g, e[6:0]});
    wr(8'he6, e[14:7]);
    wr(8'he7, {4'h0, e[18:15]});
  endtask

  task automatic raise(input int i);
    if (i == 0 || i == 2)
      ext_pending_set[i / 2] = 1'b1;
    else if (i == 1 || i == 3)
      tmr_set[i / 2] = 1'b1;
    else
      fl[i] = 1'b1;
    cyc(1);
    ext_pending_set = 2'h0;
    tmr_set = 2'h0;
  endtask

  task automatic waitv(input int s);
    repeat (20) if (st[s] !== 1'b1) cyc(1);
  endtask

  task automatic take(input int s);
    take_en = 1'b1;
    waitv(s);
    take_en = 1'b0;
  endtask

  task automatic reti();
    reti_cmd = 1'b1;
    cyc(1);
    reti_cmd = 1'b0;
    cyc(3);
  endtask

  task report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    {sfr_wr, sfr_rd, take_en, reti_cmd, rst_n} = 5'h0;
    {sfr_addr, sfr_wdata, ext_pending_set, ext_pending_clear, tmr_set, sub} = 0;
    {ext_line0_input, ext_line1_input, take_delay, fl} = {2'h3, 22'h0};
    void'($urandom(32'hf154));
    cyc(2);
    rst_n = 1'b1;
    // ==========================================================
    // Register reset values and access
    rd(8'ha8, 8'h00, "mask reset");
    rd(8'hb8, 8'h80, "prio reset");
    rd(8'h00, 8'h00, "unmapped");
    x = 8'($urandom);
    wr(8'he6, x);
    rd(8'he6, x, "ext enable1");
    wr(8'hf6, ~x);
    rd(8'hf6, ~x, "ext prio1");
    wr(8'hf7, x);
    rd(8'hf7, {4'h0, x[3:0]}, "ext prio2");
    wr(8'hf6, 8'h00);
    wr(8'hf7, 8'h00);
    $display("test registers done");
    // ==========================================================
    // Global gate holds pending requests back
    set_en(19'h7ffff, 1'b0);
    fl = 19'($urandom) & 19'h7fff0;
    fl[4] = 1'b1;
    cyc(3);
    chk(cpu_irq_req, 0, "gated req");
    wr(8'ha8, 8'hff);
    cyc(1);
    chk(cpu_irq_req, 1, "released req");
    fl = 0;
    cyc(2);
    $display("test global gate done");
    // ==========================================================
    // Every source alone: vector, hardware clear, enable as the only stop
    for (int i = 0; i < 19; i++)
    begin
      sub = 2'($urandom);
      take_delay = 3'($urandom);
      set_en(19'(1) << i, 1'b1);
      raise(i);
      waitv(0);
      chk(cpu_irq_vector, exp_vec(i), "vector");
      take(1);
      if (i < 3)
        chk({ext_line1_pending, ext_line0_pending}, 0, "hw clear");
      reti();
      chk(cpu_irq_req, 16'(i > 3), "req after return");
      if (i > 3)
      begin
        set_en(19'h0, 1'b1);
        chk(cpu_irq_req, 0, "enable stop");
      end
      fl = 0;
      cyc(2);
    end
    $display("test source table done");
    // ==========================================================
    // Fixed order, then preemption by the high level
    a = 4 + $urandom_range(0, 1);
    b = a + 1 + $urandom_range(0, 5 - a);
    set_en((19'(1) << a) | (19'(1) << b), 1'b1);
    fl[a] = 1'b1;
    fl[b] = 1'b1;
    waitv(0);
    chk(cpu_irq_vector, exp_vec(a), "fixed order");
    fl = 0;
    wr(8'hb8, 8'(1 << a));
    fl[b] = 1'b1;
    waitv(0);
    chk(cpu_irq_vector, exp_vec(b), "low first");
    take(1);
    fl[a] = 1'b1;
    waitv(0);
    chk(cpu_irq_vector, exp_vec(a), "preempt");
    take(2);
    cyc(3);
    chk(cpu_irq_req, 0, "no preempt of high");
    fl = 0;
    reti();
    reti();
    chk(st, 0, "nesting empty");
    $display("test priority done");
    // ==========================================================
    // Falling pin sets pending with every enable off
    set_en(19'h0, 1'b0);
    {ext_line1_input, ext_line0_input} = 2'h0;
    repeat (8) if (ext_line0_pending !== 1'b1) cyc(1);
    chk(ext_line0_pending, 1, "pin pending");
    chk(ext_line1_pending, 1, "pin1 pending");
    {ext_line1_input, ext_line0_input} = 2'h3;
    ext_pending_clear = 2'h3;
    cyc(1);
    ext_pending_clear = 2'h0;
    cyc(1);
    chk(ext_line0_pending, 0, "sw clear");
    chk(ext_line1_pending, 0, "sw1 clear");
    $display("test pin edge done");
    report_and_stop();
  end
endmodule
